// >>> hw/hsssc_top.sv
`timescale 1ns/1ps
`default_nettype none
module hsssc_top #(
  parameter int NUM_OUT = hsssc_pkg::NUM_OUT
) (
  input  wire logic                      clk_sys,
  input  wire logic                      rst_n,
  input  wire hsssc_pkg::hsssc_req_type  reg_req,
  input  wire logic                      soft_reset,
  input  wire logic                      restart,
  input  wire hsssc_pkg::hsssc_mode_type mode,
  input  wire hsssc_pkg::hsssc_fault_type fault,
  input  wire logic [NUM_OUT-1:0]        sw_request,
  input  wire logic [NUM_OUT-1:0]        sw_cfg_write,
  output logic [15:0]                    reg_rdata,
  output logic [NUM_OUT-1:0]             out_enable,
  output logic [NUM_OUT-1:0]             out_held
);
  logic [15:0] ctrl;

  wire addr_hit = (reg_req.addr == hsssc_pkg::CTRL_ADDR);
  wire wr_hit   = reg_req.wr & addr_hit;
  wire rd_hit   = reg_req.rd & addr_hit;

  // one mask for store and read, so the two paths cannot drift apart
  function automatic logic [15:0] hsssc_writable(input logic [15:0] word);
    hsssc_writable = word & hsssc_pkg::CTRL_WR_MASK;
  endfunction

  // write mask keeps reserved positions at zero in storage
  wire [15:0] wr_value = hsssc_writable(reg_req.wdata); // R7

  wire [NUM_OUT-1:0] ov_rec  = ctrl[hsssc_pkg::OV_REC_LSB +: NUM_OUT];
  wire [NUM_OUT-1:0] ov_off  = ctrl[hsssc_pkg::OV_OFF_LSB +: NUM_OUT];
  wire               ot_ind  = ctrl[hsssc_pkg::OT_SCOPE_BIT];
  wire               lp_off  = ctrl[hsssc_pkg::LP_OV_OFF_BIT];
  wire               uv_off  = ctrl[hsssc_pkg::UV_OFF_BIT];
  wire               uv_rec  = ctrl[hsssc_pkg::UV_REC_BIT];
  wire               normal  = (mode == hsssc_pkg::HSSSC_MODE_NORMAL);

  wire [NUM_OUT-1:0] ov_trip;
  wire [NUM_OUT-1:0] ot_trip;
  wire [NUM_OUT-1:0] any_fault;
  wire               uv_trip = fault.undervolt & ~uv_off; // R5
  wire               ot_any  = |fault.overtemp;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_OUT; gi++) begin : g_out
      assign ov_trip[gi]   = fault.overvolt &
                             (normal ? ~ov_off[gi] : ~lp_off); // R3 R4
      assign ot_trip[gi]   = ot_ind ? fault.overtemp[gi] : ot_any; // R2
      assign any_fault[gi] = ov_trip[gi] | uv_trip | ot_trip[gi];

      hsssc_gate u_gate (
        .clk_sys    (clk_sys),
        .rst_n      (rst_n),
        .request    (sw_request[gi]),
        .cfg_write  (sw_cfg_write[gi]),
        .ov_trip    (ov_trip[gi]),
        .uv_trip    (uv_trip),
        .ot_trip    (ot_trip[gi]),
        .ov_recover (ov_rec[gi]),
        .uv_recover (uv_rec),
        .out_en     (out_enable[gi]),
        .held       (out_held[gi])
      );
    end
  endgenerate

  // restart has no path into ctrl, so configuration survives it
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= hsssc_pkg::CTRL_RESET; // R8
    end else if (soft_reset) begin
      ctrl <= hsssc_pkg::CTRL_RESET; // R8
    end else if (wr_hit) begin
      ctrl <= wr_value; // R9
    end
  end

  // unmapped reads answer zero
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= hsssc_pkg::RDATA_IDLE;
    end else if (reg_req.rd) begin
      reg_rdata <= rd_hit ? hsssc_writable(ctrl) : hsssc_pkg::RDATA_IDLE; // R7
    end
  end

  property p_reserved_zero;
    @(posedge clk_sys) disable iff (!rst_n)
      reg_req.rd |=> ((reg_rdata & ~hsssc_pkg::CTRL_WR_MASK) == 16'h0000);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) // R7
    else $error("reserved bits read nonzero");

  property p_soft_clear;
    @(posedge clk_sys) disable iff (!rst_n)
      soft_reset |=> (ctrl == 16'h0000) && !(|ov_rec) && !uv_rec;
  endproperty
  a_soft_clear: assert property (p_soft_clear) // R8
    else $error("soft reset did not clear control word");

  property p_restart_keep;
    @(posedge clk_sys) disable iff (!rst_n)
      restart && !soft_reset && !wr_hit |=> $stable(ctrl);
  endproperty
  a_restart_keep: assert property (p_restart_keep) // R9
    else $error("restart altered configuration");

  property p_ot_all;
    @(posedge clk_sys) disable iff (!rst_n)
      !ot_ind && ot_any |=> (out_enable == '0);
  endproperty
  a_ot_all: assert property (p_ot_all) // R2
    else $error("overtemp did not shut all outputs");

  property p_uv_off;
    @(posedge clk_sys) disable iff (!rst_n)
      fault.undervolt && !uv_off |=> (out_enable == '0);
  endproperty
  a_uv_off: assert property (p_uv_off) // R5
    else $error("undervoltage did not shut outputs");

  property p_lp_ov_off;
    @(posedge clk_sys) disable iff (!rst_n)
      !normal && fault.overvolt && !lp_off |=> (out_enable == '0);
  endproperty
  a_lp_ov_off: assert property (p_lp_ov_off) // R4
    else $error("low-power overvoltage did not shut outputs");

  property p_wr_masked;
    @(posedge clk_sys) disable iff (!rst_n)
      wr_hit && !soft_reset |=> (ctrl == ($past(reg_req.wdata) & hsssc_pkg::CTRL_WR_MASK));
  endproperty
  a_wr_masked: assert property (p_wr_masked) // R7
    else $error("write did not land with reserved bits dropped");

  property p_rd_unmapped;
    @(posedge clk_sys) disable iff (!rst_n)
      reg_req.rd && !addr_hit |=> (reg_rdata == hsssc_pkg::RDATA_IDLE);
  endproperty
  a_rd_unmapped: assert property (p_rd_unmapped) // R7
    else $error("unmapped read returned nonzero");

  generate
    for (gi = 0; gi < NUM_OUT; gi++) begin : g_chk
      sequence s_ov_cleared;
        $past(ov_trip[gi]) && !any_fault[gi] && ov_rec[gi] && !out_held[gi];
      endsequence
      sequence s_uv_cleared;
        $past(uv_trip) && !any_fault[gi] && uv_rec && !out_held[gi];
      endsequence

      property p_ov_normal;
        @(posedge clk_sys) disable iff (!rst_n)
          normal && fault.overvolt && !ov_off[gi] |=> !out_enable[gi];
      endproperty
      a_ov_normal: assert property (p_ov_normal) // R3
        else $error("normal overvoltage shutdown wrong");

      property p_ot_ind;
        @(posedge clk_sys) disable iff (!rst_n)
          ot_ind && fault.overtemp[gi] |=> !out_enable[gi];
      endproperty
      a_ot_ind: assert property (p_ot_ind) // R2
        else $error("affected output not shut on overtemp");

      property p_ov_recover;
        @(posedge clk_sys) disable iff (!rst_n)
          s_ov_cleared ##0 sw_request[gi] |=> out_enable[gi];
      endproperty
      a_ov_recover: assert property (p_ov_recover) // R1
        else $error("output not restored after overvoltage");

      property p_uv_recover;
        @(posedge clk_sys) disable iff (!rst_n)
          s_uv_cleared ##0 sw_request[gi] |=> out_enable[gi];
      endproperty
      a_uv_recover: assert property (p_uv_recover) // R6
        else $error("output not restored after undervoltage");

      property p_hold_off;
        @(posedge clk_sys) disable iff (!rst_n)
          out_held[gi] && !sw_cfg_write[gi] |=> !out_enable[gi] && out_held[gi];
      endproperty
      a_hold_off: assert property (p_hold_off) // R10
        else $error("held output released without rewrite");

      // running output with only a suppressed cause must stay on
      property p_ov_keep;
        @(posedge clk_sys) disable iff (!rst_n)
          normal && fault.overvolt && ov_off[gi] && !uv_trip && !ot_trip[gi]
            && out_enable[gi] && sw_request[gi] |=> out_enable[gi];
      endproperty
      a_ov_keep: assert property (p_ov_keep) // R3
        else $error("output dropped despite overvoltage shutdown disabled");

      property p_lp_keep;
        @(posedge clk_sys) disable iff (!rst_n)
          !normal && fault.overvolt && lp_off && !uv_trip && !ot_trip[gi]
            && out_enable[gi] && sw_request[gi] |=> out_enable[gi];
      endproperty
      a_lp_keep: assert property (p_lp_keep) // R4
        else $error("output dropped despite low-power shutdown disabled");

      property p_uv_keep;
        @(posedge clk_sys) disable iff (!rst_n)
          fault.undervolt && uv_off && !ov_trip[gi] && !ot_trip[gi]
            && out_enable[gi] && sw_request[gi] |=> out_enable[gi];
      endproperty
      a_uv_keep: assert property (p_uv_keep) // R5
        else $error("output dropped despite undervoltage shutdown disabled");

      property p_ot_spare;
        @(posedge clk_sys) disable iff (!rst_n)
          ot_ind && ot_any && !fault.overtemp[gi] && !ov_trip[gi] && !uv_trip
            && out_enable[gi] && sw_request[gi] |=> out_enable[gi];
      endproperty
      a_ot_spare: assert property (p_ot_spare) // R2
        else $error("unaffected output shut on individual overtemp");

      property p_ov_latch;
        @(posedge clk_sys) disable iff (!rst_n)
          ov_trip[gi] && !ov_rec[gi] |=> out_held[gi];
      endproperty
      a_ov_latch: assert property (p_ov_latch) // R1
        else $error("overvoltage without recovery did not latch off");

      property p_uv_latch;
        @(posedge clk_sys) disable iff (!rst_n)
          uv_trip && !uv_rec |=> out_held[gi];
      endproperty
      a_uv_latch: assert property (p_uv_latch) // R6
        else $error("undervoltage without recovery did not latch off");

      property p_release;
        @(posedge clk_sys) disable iff (!rst_n)
          out_held[gi] && sw_cfg_write[gi] && !any_fault[gi]
            |=> !out_held[gi] && (out_enable[gi] == $past(sw_request[gi]));
      endproperty
      a_release: assert property (p_release) // R10
        else $error("rewrite after fault did not release output");
    end
  endgenerate
endmodule
`default_nettype wire

// >>> common/hsssc_pkg.sv
// Overview of operation
// R1 - per-output overvoltage recovery restores previous state
// R2 - overtemp scope: all outputs or only affected
// R3 - normal mode per-output overvoltage shutdown disable
// R4 - shared stop/sleep overvoltage shutdown disable
// R5 - shared undervoltage shutdown disable bit
// R6 - shared undervoltage recovery restores previous state
// R7 - reserved bits always read zero
// R8 - power-on or soft reset clears word
// R9 - restart keeps configuration bits unchanged
// R10 - unrecovered trip holds off until reconfigured
`default_nettype none
package hsssc_pkg;
  localparam int             NUM_OUT        = 3;
  localparam int             ADDR_W         = 7;
  localparam int             DATA_W         = 16;
  localparam logic [6:0]     CTRL_ADDR      = 7'h07;
  localparam logic [15:0]    CTRL_RESET     = 16'h0000;
  localparam logic [15:0]    CTRL_WR_MASK   = 16'h7be8;
  localparam int             OV_REC_LSB     = 12;
  localparam int             OT_SCOPE_BIT   = 11;
  localparam int             OV_OFF_LSB     = 7;
  localparam int             LP_OV_OFF_BIT  = 6;
  localparam int             UV_OFF_BIT     = 5;
  localparam int             UV_REC_BIT     = 3;
  localparam logic [15:0]    RDATA_IDLE     = 16'h0000;

  typedef enum logic {
    HSSSC_MODE_NORMAL,
    HSSSC_MODE_LOWPOWER
  } hsssc_mode_type;

  typedef struct packed {
    logic       overvolt;
    logic       undervolt;
    logic [2:0] overtemp;
  } hsssc_fault_type;

  typedef struct packed {
    logic [6:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } hsssc_req_type;
endpackage
`default_nettype wire

// >>> hw/hsssc_gate.sv
`timescale 1ns/1ps
`default_nettype none
module hsssc_gate (
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic request,
  input  wire logic cfg_write,
  input  wire logic ov_trip,
  input  wire logic uv_trip,
  input  wire logic ot_trip,
  input  wire logic ov_recover,
  input  wire logic uv_recover,
  output logic      out_en,
  output logic      held
);
  typedef enum logic [1:0] {
    HSSSC_RUN,
    HSSSC_TRIP_REC,
    HSSSC_TRIP_HOLD
  } hsssc_gate_state_type;

  hsssc_gate_state_type state;
  hsssc_gate_state_type next_state;

  wire fault_now = ov_trip | uv_trip | ot_trip;
  // overtemp has no recovery bit, so it always latches off
  wire no_rec    = (ov_trip & ~ov_recover) | (uv_trip & ~uv_recover) | ot_trip; // R1 R6 R10

  always_comb begin
    next_state = state;
    unique case (state)
      HSSSC_RUN: begin
        if (fault_now) begin
          next_state = no_rec ? HSSSC_TRIP_HOLD : HSSSC_TRIP_REC;
        end
      end
      HSSSC_TRIP_REC: begin
        if (no_rec) begin
          next_state = HSSSC_TRIP_HOLD;
        end else if (!fault_now) begin
          next_state = HSSSC_RUN; // R1 R6
        end
      end
      HSSSC_TRIP_HOLD: begin
        // a rewrite during a live fault does not release
        if (cfg_write && !fault_now) begin
          next_state = HSSSC_RUN; // R10
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state  <= HSSSC_RUN;
      out_en <= 1'b0;
      held   <= 1'b0;
    end else begin
      state  <= next_state;
      out_en <= request & ~fault_now & (next_state == HSSSC_RUN);
      held   <= (next_state == HSSSC_TRIP_HOLD);
    end
  end
endmodule
`default_nettype wire

// >>> tb/hsssc_tb.sv
`timescale 1ns/1ps
`default_nettype none
module hs_switch_shutdown_ctrl_tb_top;
  logic                       clk_sys = 1'b0;
  logic                       rst_n   = 1'b0;
  hsssc_pkg::hsssc_req_type   reg_req = '0;
  logic                       soft_reset = 1'b0;
  logic                       restart    = 1'b0;
  hsssc_pkg::hsssc_mode_type  mode       = hsssc_pkg::HSSSC_MODE_NORMAL;
  hsssc_pkg::hsssc_fault_type fault      = '0;
  logic [2:0]                 sw_request   = 3'h7;
  logic [2:0]                 sw_cfg_write = 3'h0;
  logic [15:0]                reg_rdata;
  logic [2:0]                 out_enable;
  logic [2:0]                 out_held;
  int                         n_mismatch = 0;
  int                         n_tests    = 0;

  always #5 clk_sys = ~clk_sys;

  hsssc_top dut (
    .clk_sys      (clk_sys),
    .rst_n        (rst_n),
    .reg_req      (reg_req),
    .soft_reset   (soft_reset),
    .restart      (restart),
    .mode         (mode),
    .fault        (fault),
    .sw_request   (sw_request),
    .sw_cfg_write (sw_cfg_write),
    .reg_rdata    (reg_rdata),
    .out_enable   (out_enable),
    .out_held     (out_held)
  );

  task automatic chk_reg(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t reg read %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_out(input logic [2:0] got, input logic [2:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t outputs %b expected %b", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    @(negedge clk_sys);
    reg_req.addr  = a;
    reg_req.wdata = d;
    reg_req.wr    = 1'b1;
    @(negedge clk_sys);
    reg_req.wr = 1'b0;
  endtask

  task automatic rd(input logic [6:0] a, input logic [15:0] exp);
    @(negedge clk_sys);
    reg_req.addr = a;
    reg_req.rd   = 1'b1;
    @(negedge clk_sys);
    reg_req.rd = 1'b0;
    chk_reg(reg_rdata, exp);
  endtask

  // fault held for a few cycles, then cleared, then every output reconfigured
  task automatic trip(input logic [15:0] c, input logic m, input logic [4:0] f,
                      input logic [2:0] e_on, input logic [2:0] e_off);
    wr(7'h07, c);
    mode = hsssc_pkg::hsssc_mode_type'(m);
    fault = f;
    repeat (3) @(negedge clk_sys);
    chk_out(out_enable, e_on);
    // a rewrite during the fault must not release anything
    sw_cfg_write = 3'h7;
    @(negedge clk_sys);
    sw_cfg_write = 3'h0;
    repeat (2) @(negedge clk_sys);
    chk_out(out_enable, e_on);
    fault = '0;
    repeat (3) @(negedge clk_sys);
    chk_out(out_enable, e_off);
    chk_out(out_held, ~e_off);
    mode = hsssc_pkg::HSSSC_MODE_NORMAL;
    sw_cfg_write = 3'h7;
    @(negedge clk_sys);
    sw_cfg_write = 3'h0;
    repeat (2) @(negedge clk_sys);
    chk_out(out_enable, 3'h7);
    chk_out(out_held, 3'h0);
  endtask

  task automatic wrap_up;
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    #100000;
    n_mismatch++;
    wrap_up();
  end

  initial begin
    repeat (16) @(negedge clk_sys);
    rst_n = 1'b1;
    rd(7'h07, 16'h0000);
    wr(7'h07, 16'hffff);
    rd(7'h07, 16'h7be8);
    wr(7'h08, 16'h0000);
    rd(7'h07, 16'h7be8);
    rd(7'h08, 16'h0000);
    @(negedge clk_sys);
    restart = 1'b1;
    @(negedge clk_sys);
    restart = 1'b0;
    rd(7'h07, 16'h7be8);
    @(negedge clk_sys);
    soft_reset = 1'b1;
    @(negedge clk_sys);
    soft_reset = 1'b0;
    rd(7'h07, 16'h0000);
    repeat (2) @(negedge clk_sys);
    chk_out(out_enable, 3'h7);
    trip(16'h0000, 1'b0, 5'b10000, 3'b000, 3'b000);
    trip(16'h0280, 1'b0, 5'b10000, 3'b101, 3'b101);
    trip(16'h5000, 1'b0, 5'b10000, 3'b000, 3'b101);
    trip(16'h0040, 1'b1, 5'b10000, 3'b111, 3'b111);
    trip(16'h0380, 1'b1, 5'b10000, 3'b000, 3'b000);
    trip(16'h0000, 1'b0, 5'b01000, 3'b000, 3'b000);
    trip(16'h0020, 1'b0, 5'b01000, 3'b111, 3'b111);
    trip(16'h0008, 1'b0, 5'b01000, 3'b000, 3'b111);
    trip(16'h0000, 1'b0, 5'b00001, 3'b000, 3'b000);
    trip(16'h0800, 1'b0, 5'b00001, 3'b110, 3'b110);
    wrap_up();
  end
endmodule
`default_nettype wire
